/* File: sysctl_regs_pkg.sv */
// Constants for the system control register bank.
// Assumes an APB slave with 32-bit data; each 64-bit register is two words.
// Behaviour
// - Read-only 64-bit reset vector base register holds the 64-bit start address.
// - Reset vector bits 1:0 always read zero for word alignment.
// - Reset vector bits 63:40 always read zero.
// - Lower-level control register is 64 bits, resets to its fixed value.
// - Exception entry copies that level's bit 44 into the store-safe state.
// - Hypervisor store-safe control stays at bit 44 regardless of other controls.
// - Pointer authentication bits 31, 30, 27, 13 enable when set.
// - Lower-level bit 25 selects big-endian data when set.
// - Lower-level bit 21 requests sync events on entry and return.
// - Hypervisor bit 21 requests sync events on entry and return.
// - Lower-level bit 7 reads zero, writes ignored.
// - With bit 6 clear, acquire/release crossing 16 bytes faults.
// - With bit 6 set, crossing 16 bytes does not fault.
// - Bit 6 resets to an undefined value; software must set it.
// - Bit 5 clear makes legacy barriers undefined; set executes them.
// - Lower-level bit 0 enables stage 1 translation for low levels.
// - Hypervisor control register is 64 bits, resets to its fixed value.
// - Without hypervisor level, its control register reads zero, ignores writes.
package sysctl_regs_pkg;
  localparam logic [11:0] RVB_LO_OFF  = 12'h000;
  localparam logic [11:0] RVB_HI_OFF  = 12'h004;
  localparam logic [11:0] LOW_LO_OFF  = 12'h008;
  localparam logic [11:0] LOW_HI_OFF  = 12'h00C;
  localparam logic [11:0] HYP_LO_OFF  = 12'h010;
  localparam logic [11:0] HYP_HI_OFF  = 12'h014;
  localparam logic [11:0] STATE_OFF   = 12'h018;
  localparam logic [63:0] LOW_RESET   = 64'h0000_0000_30D5_0838;
  localparam logic [63:0] HYP_RESET   = 64'h0000_0000_30C5_0838;
  // Writable bits; others are fixed at their reset value
  localparam logic [63:0] LOW_WMASK   = 64'h0000_1000_CA20_2061;
  localparam logic [63:0] HYP_WMASK   = 64'h0000_1000_C820_2041;
  localparam logic [63:0] RVB_MASK    = 64'h0000_00FF_FFFF_FFFC;
  localparam int          STORE_SAFE_BIT = 44;
  localparam int          EN_IA_BIT   = 31;
  localparam int          EN_IB_BIT   = 30;
  localparam int          EN_DA_BIT   = 27;
  localparam int          ENDIAN_BIT  = 25;
  localparam int          ERR_SYNC_BIT = 21;
  localparam int          EN_DB_BIT   = 13;
  localparam int          IT_DISABLE_BIT = 7;
  localparam int          UNALIGN_OK_BIT = 6;
  localparam int          BAR_BIT     = 5;
  localparam int          MMU_BIT     = 0;
  localparam logic [3:0]  ALIGN_BLOCK = 4'hF;
endpackage

/* File: system_control_regs.sv */
// System control register bank with APB access and core-side decode.
// Assumes a synchronous core reset and core events as one-cycle pulses.
`timescale 1ns/1ps
module system_control_regs #(
  parameter logic [63:0] RESET_VECTOR = 64'h0000_0000_0000_0000,
  parameter bit          HYP_PRESENT  = 1'b1,
  parameter logic        UNALIGN_RESET = 1'b0
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core events: exception taken, return executed, and at which level
  input  wire logic        excEntry,
  input  wire logic        excReturn,
  input  wire logic        excToHyp,
  // Acquire/release access check
  input  wire logic        acqRelAccess,
  input  wire logic        accessAtHyp,
  input  wire logic [3:0]  accessAddrLow,
  input  wire logic [4:0]  accessSize,
  // Legacy barrier decode
  input  wire logic        legacyBarrier,
  // Control outputs
  output logic [63:0]      reset_start_address,
  output logic             speculative_store_safe_state,
  output logic             errSyncEvent,
  output logic             alignFault,
  output logic             legacyBarrierUndef,
  output logic             mmuEnable,
  output logic             lowBigEndian,
  output logic             hypBigEndian,
  output logic [3:0]       lowPtrAuthEnable,
  output logic [3:0]       hypPtrAuthEnable
);
  // Reset image of each control word; the alignment control has no
  // defined reset state, so its value is left to the integrator
  localparam logic [63:0] UNALIGN_ONE =
    64'h1 << sysctl_regs_pkg::UNALIGN_OK_BIT;
  localparam logic [63:0] UNALIGN_INIT =
    UNALIGN_RESET ? UNALIGN_ONE : 64'h0;
  localparam logic [63:0] LOW_INIT =
    (sysctl_regs_pkg::LOW_RESET & ~UNALIGN_ONE) | UNALIGN_INIT;
  localparam logic [63:0] HYP_INIT =
    HYP_PRESENT ? ((sysctl_regs_pkg::HYP_RESET & ~UNALIGN_ONE)
                   | UNALIGN_INIT)
                : 64'h0;

  // Control words
  logic [63:0] lowCtl_reg;
  logic [63:0] lowCtl_next;
  logic [63:0] hypCtl_reg;
  logic [63:0] hypCtl_next;
  logic [63:0] hypView;
  // Core-side state and pulses
  logic        storeSafe_reg;
  logic        storeSafe_next;
  logic        sync_reg;
  logic        sync_next;
  logic        fault_reg;
  logic        fault_next;
  logic        undef_reg;
  logic        undef_next;
  logic [4:0]  lastByte;
  logic        crossing;
  // Bus side
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic        waitDone_reg;
  logic        waitDone_next;
  logic        access;
  logic        firstCycle;
  logic        commit;
  logic        validAddr;
  logic [31:0] byteMask;

  // Merge a 32-bit write, honouring byte lanes and the writable mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] bm,
                                        input logic [31:0] wm);
    logic [31:0] be;
    be = bm & wm;
    return (old & ~be) | (wd & be);
  endfunction

  // Pointer authentication enables packed as IA, IB, DA, DB
  function automatic logic [3:0] ptrAuth(input logic [63:0] r);
    return {r[sysctl_regs_pkg::EN_IA_BIT], r[sysctl_regs_pkg::EN_IB_BIT],
            r[sysctl_regs_pkg::EN_DA_BIT], r[sysctl_regs_pkg::EN_DB_BIT]};
  endfunction

  // One control bit of the level that an event or access belongs to
  function automatic logic levelBit(input logic        hyp,
                                    input logic [63:0] low,
                                    input logic [63:0] hv,
                                    input int          pos);
    logic [63:0] word;
    word = hyp ? hv : low;
    return word[pos];
  endfunction

  // One byte lane of the write mask per strobe bit
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign byteMask[8*lane +: 8] = {8{pstrb[lane]}};
  end

  // One wait state: the first access cycle loads the read data into a
  // flop and the second answers, so prdata stands while pready is high
  assign access     = psel & penable;
  assign firstCycle = access & ~waitDone_reg;
  assign commit     = access & waitDone_reg;
  assign pready     = waitDone_reg;
  assign prdata     = rdata_reg;
  assign pslverr    = err_reg;
  assign validAddr  = (paddr <= sysctl_regs_pkg::STATE_OFF)
                      && (paddr[1:0] == 2'b00);
  // Without the hypervisor level its word reads as zero
  assign hypView    = HYP_PRESENT ? hypCtl_reg : 64'h0;

  // Bus group: read data and error, both valid in the answering cycle
  always_comb begin
    rdata_next    = rdata_reg;
    err_next      = 1'b0;
    waitDone_next = firstCycle;
    if (firstCycle) begin
      err_next = !validAddr;
    end
    if (firstCycle && !pwrite) begin
      rdata_next = 32'h0000_0000;
      if (validAddr) begin
        unique case (paddr)
          sysctl_regs_pkg::RVB_LO_OFF: begin
            rdata_next = reset_start_address[31:0];
          end
          sysctl_regs_pkg::RVB_HI_OFF: begin
            rdata_next = reset_start_address[63:32];
          end
          sysctl_regs_pkg::LOW_LO_OFF: begin
            rdata_next = lowCtl_reg[31:0];
          end
          sysctl_regs_pkg::LOW_HI_OFF: begin
            rdata_next = lowCtl_reg[63:32];
          end
          sysctl_regs_pkg::HYP_LO_OFF: begin
            rdata_next = hypView[31:0];
          end
          sysctl_regs_pkg::HYP_HI_OFF: begin
            rdata_next = hypView[63:32];
          end
          default: begin
            rdata_next = {31'h0000_0000, storeSafe_reg};
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_reg    <= 32'h0000_0000;
      err_reg      <= 1'b0;
      waitDone_reg <= 1'b0;
    end else begin
      rdata_reg    <= rdata_next;
      err_reg      <= err_next;
      waitDone_reg <= waitDone_next;
    end
  end

  // Control group: a write lands only at the edge that completes it
  always_comb begin
    lowCtl_next = lowCtl_reg;
    hypCtl_next = hypCtl_reg;
    if (commit && pwrite && validAddr) begin
      unique case (paddr)
        sysctl_regs_pkg::LOW_LO_OFF: begin
          lowCtl_next[31:0] = merge(lowCtl_reg[31:0], pwdata, byteMask,
                                    sysctl_regs_pkg::LOW_WMASK[31:0]);
        end
        sysctl_regs_pkg::LOW_HI_OFF: begin
          lowCtl_next[63:32] = merge(lowCtl_reg[63:32], pwdata, byteMask,
                                     sysctl_regs_pkg::LOW_WMASK[63:32]);
        end
        sysctl_regs_pkg::HYP_LO_OFF: begin
          if (HYP_PRESENT) begin
            hypCtl_next[31:0] = merge(hypCtl_reg[31:0], pwdata, byteMask,
                                      sysctl_regs_pkg::HYP_WMASK[31:0]);
          end
        end
        sysctl_regs_pkg::HYP_HI_OFF: begin
          if (HYP_PRESENT) begin
            hypCtl_next[63:32] = merge(hypCtl_reg[63:32], pwdata, byteMask,
                                       sysctl_regs_pkg::HYP_WMASK[63:32]);
          end
        end
        // Reset vector and state words are read-only
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lowCtl_reg <= LOW_INIT;
      hypCtl_reg <= HYP_INIT;
    end else begin
      lowCtl_reg <= lowCtl_next;
      hypCtl_reg <= hypCtl_next;
    end
  end

  // Event group: core pulses answered one cycle later
  always_comb begin
    storeSafe_next = storeSafe_reg;
    sync_next      = 1'b0;
    fault_next     = 1'b0;
    undef_next     = 1'b0;
    // Crossing is a carry out of the low four address bits
    lastByte       = {1'b0, accessAddrLow} + accessSize - 5'h01;
    crossing       = lastByte[4];
    if (excEntry) begin
      storeSafe_next = levelBit(excToHyp, lowCtl_reg, hypView,
                                sysctl_regs_pkg::STORE_SAFE_BIT);
    end
    if (excEntry || excReturn) begin
      sync_next = levelBit(excToHyp, lowCtl_reg, hypView,
                           sysctl_regs_pkg::ERR_SYNC_BIT);
    end
    // A zero-size access touches no bytes and cannot cross
    if (acqRelAccess && accessSize != 5'h00) begin
      fault_next = crossing
                   && !levelBit(accessAtHyp, lowCtl_reg, hypView,
                                sysctl_regs_pkg::UNALIGN_OK_BIT);
    end
    if (legacyBarrier) begin
      undef_next = !lowCtl_reg[sysctl_regs_pkg::BAR_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      storeSafe_reg <= 1'b0;
      sync_reg      <= 1'b0;
      fault_reg     <= 1'b0;
      undef_reg     <= 1'b0;
    end else begin
      storeSafe_reg <= storeSafe_next;
      sync_reg      <= sync_next;
      fault_reg     <= fault_next;
      undef_reg     <= undef_next;
    end
  end

  // Outputs
  assign reset_start_address = RESET_VECTOR
                               & sysctl_regs_pkg::RVB_MASK;
  assign speculative_store_safe_state = storeSafe_reg;
  assign errSyncEvent       = sync_reg;
  assign alignFault         = fault_reg;
  assign legacyBarrierUndef = undef_reg;
  assign mmuEnable    = lowCtl_reg[sysctl_regs_pkg::MMU_BIT];
  assign lowBigEndian = lowCtl_reg[sysctl_regs_pkg::ENDIAN_BIT];
  assign hypBigEndian = hypView[sysctl_regs_pkg::ENDIAN_BIT];
  assign lowPtrAuthEnable = ptrAuth(lowCtl_reg);
  assign hypPtrAuthEnable = ptrAuth(hypView);
endmodule

/* File: system_control_regs_asserts.sv */
// Checker for the system control register bank, bound to its top module.
// Assumes APB writes land in the access cycle with pready high; core events are one-cycle pulses.
`timescale 1ns/1ps
module system_control_regs_asserts (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        excEntry,
  input wire logic        excReturn,
  input wire logic        excToHyp,
  input wire logic        acqRelAccess,
  input wire logic        accessAtHyp,
  input wire logic [3:0]  accessAddrLow,
  input wire logic [4:0]  accessSize,
  input wire logic        legacyBarrier,
  input wire logic [63:0] reset_start_address,
  input wire logic        errSyncEvent,
  input wire logic        alignFault,
  input wire logic        legacyBarrierUndef,
  input wire logic        mmuEnable,
  input wire logic        lowBigEndian,
  input wire logic [3:0]  lowPtrAuthEnable
);
  // Shadow of the low words, so outputs can be tied to what software wrote
  logic [31:0] low_reg, low_next, hyp_reg, hyp_next, bm;
  logic        syncWant, faultWant;
  always_comb begin
    bm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    low_next = low_reg;
    hyp_next = hyp_reg;
    if (psel && penable && pready && pwrite && paddr == 12'h008)
      low_next = (low_reg & ~(bm & 32'hCA20_2061)) | (pwdata & bm & 32'hCA20_2061);
    if (psel && penable && pready && pwrite && paddr == 12'h010)
      hyp_next = (hyp_reg & ~(bm & 32'hC820_2041)) | (pwdata & bm & 32'hC820_2041);
    syncWant = (excEntry || excReturn) && (excToHyp ? hyp_reg[21] : low_reg[21]);
    faultWant = acqRelAccess && !(accessAtHyp ? hyp_reg[6] : low_reg[6])
      && ({2'h0, accessAddrLow} + {1'h0, accessSize} > 6'h10);
  end
  always_ff @(posedge core_clk)
    if (srst) {low_reg, hyp_reg} <= {32'h30D5_0838, 32'h30C5_0838};
    else {low_reg, hyp_reg} <= {low_next, hyp_next};
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_vector_zero_bits: assert property (reset_start_address[1:0] == 2'h0 && reset_start_address[63:40] == 24'h0)
    else $error("reset vector has nonzero fixed bits");
  a_vector_fixed: assert property ($stable(reset_start_address))
    else $error("reset vector changed");
  a_mmu_bit: assert property (mmuEnable == low_reg[0])
    else $error("mmu enable differs from register");
  a_endian_bit: assert property (lowBigEndian == low_reg[25])
    else $error("endianness differs from register");
  a_auth_bits: assert property (lowPtrAuthEnable == {low_reg[31], low_reg[30], low_reg[27], low_reg[13]})
    else $error("pointer auth enables differ from register");
  a_barrier_gate: assert property (1 |=> legacyBarrierUndef == $past(legacyBarrier && !low_reg[5]))
    else $error("barrier undefined pulse wrong");
  a_sync_event: assert property (1 |=> errSyncEvent == $past(syncWant))
    else $error("sync event pulse wrong");
  a_align_fault: assert property (1 |=> alignFault == $past(faultWant))
    else $error("alignment fault pulse wrong");
  c_sync: cover property (syncWant);
  c_fault: cover property (faultWant);
  c_barrier: cover property (legacyBarrier && !low_reg[5]);
endmodule
bind system_control_regs system_control_regs_asserts i_chk (.*);

/* File: test_system_control_regs.sv */
// Self-checking bench for the system control register bank over APB.
// Assumes read data and error are valid in the completing cycle, while pready is high.
`timescale 1ns/1ps
module test_system_control_regs;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic excEntry, excReturn, excToHyp, acqRelAccess, accessAtHyp;
  logic legacyBarrier, speculative_store_safe_state, errSyncEvent;
  logic alignFault, legacyBarrierUndef, mmuEnable, lowBigEndian, hypBigEndian;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, wv;
  logic [3:0]  pstrb, accessAddrLow, lowPtrAuthEnable, hypPtrAuthEnable;
  logic [4:0]  accessSize;
  logic [63:0] reset_start_address;
  int          errors, n_checks;
  system_control_regs #(.RESET_VECTOR(64'hFFFF_FFFF_FFFF_FFFF)) i_dut (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    // The answer is taken at the edge where pready is seen high
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic [4:0] ev, input logic [3:0] ad);
    @(posedge core_clk);
    {excEntry, excReturn, excToHyp, acqRelAccess, legacyBarrier} <= ev;
    {accessAtHyp, accessAddrLow, accessSize} <= {ev[2], ad, 5'h2};
    @(posedge core_clk);
    {excEntry, excReturn, acqRelAccess, legacyBarrier} <= 4'h0;
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 12'h0, 32'h0, 4'hF};
    {excEntry, excReturn, excToHyp, acqRelAccess, accessAtHyp} = 5'h0;
    {legacyBarrier, accessAddrLow, accessSize} = {1'b0, 4'h0, 5'h1};
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rdchk(12'h000, 32'hFFFF_FFFC);
    rdchk(12'h004, 32'h0000_00FF);
    rdchk(12'h008, 32'h30D5_0838);
    rdchk(12'h00C, 32'h0);
    rdchk(12'h010, 32'h30C5_0838);
    rdchk(12'h014, 32'h0);
    $display("reset value test done");
    for (int v = 0; v < 2; v++) begin
      wv = v ? 32'hFFFF_FFFF : 32'h0;
      apb(1'b1, 12'h008, wv);
      apb(1'b1, 12'h010, wv);
      rdchk(12'h008, (32'h30D5_0838 & 32'h35DF_DF9E)
                     | (wv & 32'hCA20_2061));
      chk({mmuEnable, lowBigEndian, lowPtrAuthEnable}, {wv[0], wv[25], {4{wv[0]}}});
      chk({hypBigEndian, hypPtrAuthEnable}, {1'b0, {4{wv[0]}}});
      rdchk(12'h010, 32'h30C5_0838 | (wv & 32'hC820_2041));
      pulse(5'b10001, 4'hF);
      chk({errSyncEvent, legacyBarrierUndef}, {wv[21], !wv[5]});
      pulse(5'b01110, 4'hF);
      chk({errSyncEvent, alignFault}, {wv[21], !wv[6]});
      pulse(5'b00010, 4'hE);
      chk(alignFault, 1'b0);
    end
    $display("control bit test done");
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    rdchk(12'h00C, 32'h0000_1000);
    apb(1'b1, 12'h014, 32'h0);
    pulse(5'b10000, 4'h0);
    chk(speculative_store_safe_state, 1'b1);
    pulse(5'b10100, 4'h0);
    chk(speculative_store_safe_state, 1'b0);
    apb(1'b1, 12'h014, 32'hFFFF_FFFF);
    pulse(5'b10100, 4'h0);
    chk(speculative_store_safe_state, 1'b1);
    rdchk(12'h018, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0);
    chk(err, 1'b0);
    rdchk(12'h000, 32'hFFFF_FFFC);
    chk(reset_start_address, 64'h0000_00FF_FFFF_FFFC);
    rdchk(12'h01C, 32'h0000_0000);
    chk(err, 1'b1);
    $display("store safe and read-only test done");
    finish_test();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    finish_test();
  end
endmodule
